/* fscr_pkg.sv */
// Constants for the status-two / persistent config-one register block
package fscr_pkg;
  localparam logic [7:0] OPC_READ_STATUS_TWO = 8'h07;
  localparam logic [7:0] OPC_READ_ANY_REG = 8'h65;
  localparam logic [7:0] OPC_WRITE_REGISTERS = 8'h01;
  localparam logic [7:0] OPC_WRITE_ANY_REG = 8'h71;
  localparam logic [7:0] OPC_WRITE_LATCH_SET = 8'h06;
  localparam logic [7:0] OPC_CLEAR_STATUS = 8'h30;
  localparam logic [23:0] ADDR_STATUS_TWO_VOL = 24'h800001;
  localparam logic [23:0] ADDR_CONFIG_ONE_NV = 24'h000002;
  localparam int BIT_ERASE_FAIL = 6;
  localparam int BIT_PROG_FAIL = 5;
  localparam int BIT_ERASE_SUSP = 1;
  localparam int BIT_PROG_SUSP = 0;
  localparam int BIT_HALT_DEF = 7;
  localparam int BIT_CMP_DEF = 6;
  localparam int BIT_LOCK_LSB = 2;
  localparam int BIT_FOUR_DEF = 1;
  localparam int BIT_FREEZE_DEF = 0;
  localparam logic [7:0] RST_STATUS_TWO = 8'h00;
  localparam logic [7:0] RST_CONFIG_ONE = 8'h00;
  localparam logic [7:0] CFG_WRITABLE_MASK = 8'h42;
  localparam logic [7:0] CFG_OTP_LOCK_MASK = 8'h3c;
  localparam logic [2:0] REGION_PROTECT_ALL = 3'h7;
  localparam logic [2:0] ADDR_LAST_BYTE = 3'h2;
  localparam logic [2:0] WRR_CFG_BYTE = 3'h1;
  localparam logic [2:0] BIT_LAST = 3'h7;

  typedef enum logic [2:0] {
    FSCR_ST_CMD = 3'b000,
    FSCR_ST_ADDR = 3'b001,
    FSCR_ST_DIN = 3'b010,
    FSCR_ST_DOUT = 3'b011,
    FSCR_ST_IGNORE = 3'b100
  } fscr_state_e;
endpackage : fscr_pkg

/* fscr_regs.sv */
// Status-two and persistent config-one registers behind a sampled serial port
`timescale 1ns/100ps
module fscr_regs
  import fscr_pkg::*;
(
  // Clock and resets
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_por_nrst,
  // Serial link, mode 0, sampled
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe,
  // Core events and states
  input wire logic i_erase_fail,
  input wire logic i_erase_protected_hit,
  input wire logic i_chip_erase_protected_hit,
  input wire logic i_program_fail,
  input wire logic i_program_protected_hit,
  input wire logic i_erase_suspended,
  input wire logic i_program_suspended,
  input wire logic [2:0] i_region_protect_select,
  // Status and volatile copies
  output logic o_busy,
  output logic o_write_latch,
  output logic o_halt_status,
  output logic o_complement_protect,
  output logic [3:0] o_region_lock,
  output logic o_four_bit_width,
  output logic o_register_freeze_bit
);

  logic [2:0] sck_s;
  logic [1:0] cs_s;
  logic [1:0] si_s;
  fscr_state_e state_reg;
  logic [2:0] bit_cnt_reg;
  logic [2:0] byte_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] op_reg;
  logic [23:0] addr_reg;
  logic [7:0] tx_reg;
  logic erase_fail_reg;
  logic prog_fail_reg;
  logic erase_susp_reg;
  logic prog_susp_reg;
  logic wel_reg;
  logic [7:0] cfg_nv_reg;
  logic erase_fail_next;
  logic prog_fail_next;
  logic [7:0] cfg_nv_next;
  logic [7:0] status_two;
  logic [7:0] rx_byte;
  logic sck_rise;
  logic sck_fall;
  logic cs_active;
  logic byte_done;
  logic clear_pulse;
  logic latch_pulse;
  logic cfg_write;
  logic frozen;

  function automatic logic [7:0] reg_read(input logic [23:0] addr, input logic [7:0] st,
                                          input logic [7:0] cfg);
    logic [7:0] val;
    val = 8'h00;
    if (addr == ADDR_STATUS_TWO_VOL) begin
      val = st;
    end else if (addr == ADDR_CONFIG_ONE_NV) begin
      val = cfg;
    end
    return val;
  endfunction : reg_read

  // Single-byte command seen: eighth bit of the opcode byte
  function automatic logic opcode_strobe(input logic done, input fscr_state_e st,
                                         input logic [7:0] rx, input logic [7:0] opc);
    return done && (st == FSCR_ST_CMD) && (rx == opc);
  endfunction : opcode_strobe

  // Link pins pass two flops; edge logic looks only at the second and later
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      sck_s <= 3'h0;
      cs_s <= 2'h3;
      si_s <= 2'h0;
    end else begin
      sck_s <= {sck_s[1:0], i_sck};
      cs_s <= {cs_s[0], i_cs_n};
      si_s <= {si_s[0], i_si};
    end
  end

  assign sck_rise = sck_s[1] & ~sck_s[2];
  assign sck_fall = ~sck_s[1] & sck_s[2];
  assign cs_active = ~cs_s[1];
  assign rx_byte = {shift_reg[6:0], si_s[1]};
  assign byte_done = cs_active && sck_rise && (bit_cnt_reg == BIT_LAST);

  // Reserved bits forced to zero
  always_comb begin
    status_two = RST_STATUS_TWO;
    status_two[BIT_ERASE_FAIL] = erase_fail_reg;
    status_two[BIT_PROG_FAIL] = prog_fail_reg;
    status_two[BIT_ERASE_SUSP] = erase_susp_reg;
    status_two[BIT_PROG_SUSP] = prog_susp_reg;
  end

  // Command decode and shifting
  always_ff @(posedge i_clk) begin
    if (!i_nrst || !cs_active) begin
      state_reg <= FSCR_ST_CMD;
      bit_cnt_reg <= 3'h0;
      byte_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      op_reg <= 8'h00;
      addr_reg <= 24'h000000;
      tx_reg <= 8'h00;
    end else if (sck_rise) begin
      shift_reg <= rx_byte;
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (byte_done) begin
        case (state_reg)
          FSCR_ST_CMD: begin
            op_reg <= rx_byte;
            byte_cnt_reg <= 3'h0;
            case (rx_byte)
              OPC_READ_STATUS_TWO: begin
                state_reg <= FSCR_ST_DOUT;
                addr_reg <= ADDR_STATUS_TWO_VOL;
                tx_reg <= status_two;
              end
              OPC_READ_ANY_REG: begin
                state_reg <= FSCR_ST_ADDR;
              end
              OPC_WRITE_ANY_REG: begin
                state_reg <= o_busy ? FSCR_ST_IGNORE : FSCR_ST_ADDR;
              end
              OPC_WRITE_REGISTERS: begin
                state_reg <= o_busy ? FSCR_ST_IGNORE : FSCR_ST_DIN;
              end
              default: begin
                state_reg <= FSCR_ST_IGNORE;
              end
            endcase
          end
          FSCR_ST_ADDR: begin
            addr_reg <= {addr_reg[15:0], rx_byte};
            byte_cnt_reg <= byte_cnt_reg + 3'h1;
            if (byte_cnt_reg == ADDR_LAST_BYTE) begin
              byte_cnt_reg <= 3'h0;
              if (op_reg == OPC_WRITE_ANY_REG) begin
                state_reg <= FSCR_ST_DIN;
              end else begin
                state_reg <= FSCR_ST_DOUT;
                // No dummy byte: data must be ready before the next falling edge
                tx_reg <= reg_read({addr_reg[15:0], rx_byte}, status_two, cfg_nv_reg);
              end
            end
          end
          FSCR_ST_DIN: begin
            // Write-registers: byte 0 belongs to status one, byte 1 is the config
            byte_cnt_reg <= byte_cnt_reg + 3'h1;
            if (op_reg == OPC_WRITE_ANY_REG || byte_cnt_reg == WRR_CFG_BYTE) begin
              state_reg <= FSCR_ST_IGNORE;
            end
          end
          FSCR_ST_DOUT: begin
            // Same register streams out until chip select rises
            tx_reg <= reg_read(addr_reg, status_two, cfg_nv_reg);
          end
          default: begin
            state_reg <= FSCR_ST_IGNORE;
          end
        endcase
      end
    end else if (sck_fall && state_reg == FSCR_ST_DOUT) begin
      tx_reg <= {tx_reg[6:0], 1'b0};
    end
  end

  // Data out changes on the falling edge so the host samples it on the rise
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_so <= 1'b0;
      o_so_oe <= 1'b0;
    end else begin
      o_so_oe <= cs_active && (state_reg == FSCR_ST_DOUT);
      if (sck_fall && cs_active && state_reg == FSCR_ST_DOUT) begin
        o_so <= tx_reg[7];
      end
    end
  end

  assign clear_pulse = opcode_strobe(byte_done, state_reg, rx_byte, OPC_CLEAR_STATUS);
  assign latch_pulse = opcode_strobe(byte_done, state_reg, rx_byte, OPC_WRITE_LATCH_SET);
  // Either the one-time default or its volatile copy blocks register writes
  assign frozen = cfg_nv_reg[BIT_FREEZE_DEF] | o_register_freeze_bit;
  // Second data byte of write-registers, or write-any-register at the config address
  assign cfg_write = byte_done && state_reg == FSCR_ST_DIN && wel_reg && !frozen &&
                     (((op_reg == OPC_WRITE_REGISTERS) && (byte_cnt_reg == WRR_CFG_BYTE)) ||
                      ((op_reg == OPC_WRITE_ANY_REG) && (addr_reg == ADDR_CONFIG_ONE_NV)));

  // Failure flags: hardware set wins over a clear in the same cycle
  always_comb begin
    erase_fail_next = erase_fail_reg;
    prog_fail_next = prog_fail_reg;
    if (clear_pulse) begin
      erase_fail_next = 1'b0;
      prog_fail_next = 1'b0;
    end
    if (i_erase_fail || i_erase_protected_hit || i_chip_erase_protected_hit) begin
      erase_fail_next = 1'b1;
    end
    if (i_program_fail || i_program_protected_hit) begin
      prog_fail_next = 1'b1;
    end
  end

  // No write path reaches these flags
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      erase_fail_reg <= 1'b0;
      prog_fail_reg <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      erase_fail_reg <= erase_fail_next;
      prog_fail_reg <= prog_fail_next;
      o_busy <= erase_fail_next | prog_fail_next;
    end
  end

  // Suspend bits mirror the core's states; no command path reaches them
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      erase_susp_reg <= 1'b0;
      prog_susp_reg <= 1'b0;
    end else begin
      erase_susp_reg <= i_erase_suspended;
      prog_susp_reg <= i_program_suspended;
    end
  end

  // Write latch: only an accepted config write consumes it, clear-status drops it too
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      wel_reg <= 1'b0;
    end else if (latch_pulse) begin
      wel_reg <= 1'b1;
    end else if (clear_pulse || cfg_write) begin
      wel_reg <= 1'b0;
    end
  end

  assign o_write_latch = wel_reg;

  // One-time bits only OR in; halt default is never written
  always_comb begin
    cfg_nv_next = cfg_nv_reg;
    cfg_nv_next[BIT_CMP_DEF] = rx_byte[BIT_CMP_DEF];
    cfg_nv_next[BIT_FOUR_DEF] = rx_byte[BIT_FOUR_DEF];
    cfg_nv_next = cfg_nv_next | (rx_byte & CFG_OTP_LOCK_MASK);
    if (i_region_protect_select == REGION_PROTECT_ALL) begin
      cfg_nv_next[BIT_FREEZE_DEF] = cfg_nv_reg[BIT_FREEZE_DEF] | rx_byte[BIT_FREEZE_DEF];
    end
    cfg_nv_next[BIT_HALT_DEF] = 1'b0;
  end

  // Persistent cells survive the ordinary reset; only power-on clears them
  always_ff @(posedge i_clk) begin
    if (!i_por_nrst) begin
      cfg_nv_reg <= RST_CONFIG_ONE;
    end else if (cfg_write) begin
      cfg_nv_reg <= cfg_nv_next;
    end
  end

  // Volatile copies load from the persistent defaults while reset is held
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_complement_protect <= cfg_nv_reg[BIT_CMP_DEF];
      o_four_bit_width <= cfg_nv_reg[BIT_FOUR_DEF];
      o_register_freeze_bit <= cfg_nv_reg[BIT_FREEZE_DEF];
    end
  end

  // Halt status starts from its default, then follows the core's suspend states
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_halt_status <= cfg_nv_reg[BIT_HALT_DEF];
    end else begin
      o_halt_status <= i_erase_suspended | i_program_suspended;
    end
  end

  // Lock copies track the one-time cells in and out of reset
  always_ff @(posedge i_clk) begin
    o_region_lock <= cfg_nv_reg[BIT_LOCK_LSB +: 4];
  end

endmodule : fscr_regs

/* fscr_regs_checker.sv */
// Port checker for the status-two / config-one register block
`timescale 1ns/100ps
module fscr_regs_checker (
  // Clock, reset, link
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_cs_n,
  // Core events
  input wire logic i_erase_fail,
  input wire logic i_erase_protected_hit,
  input wire logic i_chip_erase_protected_hit,
  input wire logic i_program_fail,
  input wire logic i_program_protected_hit,
  input wire logic i_erase_suspended,
  input wire logic i_program_suspended,
  // Outputs watched
  input wire logic o_so_oe,
  input wire logic o_busy,
  input wire logic o_write_latch,
  input wire logic o_halt_status,
  input wire logic o_complement_protect,
  input wire logic [3:0] o_region_lock,
  input wire logic o_four_bit_width,
  input wire logic o_register_freeze_bit
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  wire logic fail_ev = i_erase_fail | i_erase_protected_hit | i_chip_erase_protected_hit |
    i_program_fail | i_program_protected_hit;
  a_fail_sets_busy: assert property (fail_ev |=> o_busy)
    else $error("busy not raised by failure event");
  a_busy_no_cause: assert property (!o_busy && !fail_ev |=> !o_busy)
    else $error("busy rose without failure event");
  a_busy_holds: assert property (o_busy && i_cs_n && $past(i_cs_n, 4) |=> o_busy)
    else $error("busy dropped outside a frame");
  a_oe_idle: assert property (i_cs_n [*6] |-> !o_so_oe)
    else $error("data out driven while deselected");
  a_oe_in_frame: assert property ($rose(o_so_oe) |-> !i_cs_n)
    else $error("data out enabled without select");
  a_lock_sticky: assert property ((o_region_lock & $past(o_region_lock)) == $past(o_region_lock))
    else $error("region lock bit fell");
  a_copies_hold: assert property ($past(i_nrst) |->
    $stable({o_complement_protect, o_four_bit_width, o_register_freeze_bit}))
    else $error("volatile copy changed outside reset");
  a_halt_susp: assert property (i_erase_suspended || i_program_suspended |-> ##[1:2] o_halt_status)
    else $error("halt status missing while suspended");
  a_reset_quiet: assert property ($rose(i_nrst) |-> !o_busy && !o_so_oe && !o_write_latch)
    else $error("status not clear after reset");
  c_busy: cover property (o_busy && !i_cs_n);
  c_read: cover property ($rose(o_so_oe));
  c_latch: cover property ($rose(o_write_latch));
endmodule : fscr_regs_checker

bind fscr_regs fscr_regs_checker chk (.i_clk, .i_nrst, .i_cs_n, .i_erase_fail,
  .i_erase_protected_hit, .i_chip_erase_protected_hit, .i_program_fail,
  .i_program_protected_hit, .i_erase_suspended, .i_program_suspended, .o_so_oe, .o_busy,
  .o_write_latch, .o_halt_status, .o_complement_protect, .o_region_lock, .o_four_bit_width,
  .o_register_freeze_bit);

/* fscr_host.sv */
// Serial host model issuing register commands in mode 0
`timescale 1ns/100ps
module fscr_host (
  // Link pins
  output logic o_sck,
  output logic o_cs_n,
  output logic o_si,
  input wire logic i_so,
  input wire logic i_so_oe
);
  int half = 40;
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
  end
  // Whole frame MSB first; unread bits come back as z
  task automatic xfer(input int nbits, input logic [63:0] tx, output logic [63:0] rx);
    rx = '0;
    o_cs_n = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      o_si = tx[i];
      #(half);
      o_sck = 1'b1;
      rx[i] = i_so_oe ? i_so : 1'bz;
      #(half);
      o_sck = 1'b0;
    end
    #(half);
    o_cs_n = 1'b1;
    // Released line must not keep the last bit
    o_si = ~o_si;
    #(4 * half);
  endtask : xfer
endmodule : fscr_host

/* tb_top.sv */
// Self-checking bench for the status-two / config-one register block
`timescale 1ns/100ps
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, a); end end
module tb_top;
  import fscr_pkg::*;
  logic clk, nrst, por_nrst, sck, cs_n, si, so, so_oe, busy, latch, halt, cmp, four, frz;
  logic [3:0] lock;
  logic [4:0] ev;
  logic [1:0] susp;
  logic [2:0] sel;
  logic [63:0] rx;
  int miscompares, n_checks;
  // Events {erase, erase prot, chip prot, prog, prog prot}, suspends, status byte
  logic [4:0] row_ev [8] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h00, 5'h00, 5'h00};
  logic [1:0] row_su [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h1, 2'h0};
  logic [7:0] row_st [8] = '{8'h40, 8'h40, 8'h40, 8'h20, 8'h20, 8'h02, 8'h01, 8'h00};
  fscr_regs dut (.i_clk(clk), .i_nrst(nrst), .i_por_nrst(por_nrst), .i_sck(sck), .i_cs_n(cs_n),
    .i_si(si), .o_so(so), .o_so_oe(so_oe), .i_erase_fail(ev[4]),
    .i_erase_protected_hit(ev[3]), .i_chip_erase_protected_hit(ev[2]), .i_program_fail(ev[1]),
    .i_program_protected_hit(ev[0]), .i_erase_suspended(susp[1]),
    .i_program_suspended(susp[0]), .i_region_protect_select(sel), .o_busy(busy),
    .o_write_latch(latch), .o_halt_status(halt), .o_complement_protect(cmp),
    .o_region_lock(lock), .o_four_bit_width(four), .o_register_freeze_bit(frz));
  fscr_host host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so), .i_so_oe(so_oe));
  task automatic op(input logic [7:0] code);
    host.xfer(8, {56'h0, code}, rx);
  endtask : op
  task automatic rd(input logic [23:0] addr);
    host.xfer(40, {24'h0, OPC_READ_ANY_REG, addr, 8'h00}, rx);
  endtask : rd
  task automatic wr(input logic [23:0] addr, input logic [7:0] d);
    op(OPC_WRITE_LATCH_SET);
    host.xfer(40, {24'h0, OPC_WRITE_ANY_REG, addr, d}, rx);
  endtask : wr
  task automatic pulse(input logic [4:0] e);
    @(negedge clk);
    ev = e;
    @(negedge clk);
    ev = 5'h00;
    repeat (2) @(negedge clk);
  endtask : pulse
  task automatic rst();
    @(negedge clk);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
  endtask : rst
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Whole run is about 60 frames of a few microseconds
  initial begin
    #300000;
    miscompares++;
    summarize();
  end
  initial begin
    nrst = 1'b0;
    por_nrst = 1'b0;
    ev = 5'h00;
    susp = 2'h0;
    sel = 3'h0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    por_nrst = 1'b1;
    repeat (4) @(negedge clk);
    for (int k = 0; k < 8; k++) begin
      @(negedge clk);
      susp = row_su[k];
      pulse(row_ev[k]);
      `CHK("busy", row_ev[k] != 5'h00, busy)
      `CHK("halt", row_su[k] != 2'h0, halt)
      host.xfer(16, {48'h0, OPC_READ_STATUS_TWO, 8'h00}, rx);
      `CHK("status 07h", row_st[k], rx[7:0])
      rd(ADDR_STATUS_TWO_VOL);
      `CHK("status 65h", row_st[k], rx[7:0])
      @(negedge clk);
      susp = 2'h0;
      op(OPC_CLEAR_STATUS);
      rd(ADDR_STATUS_TWO_VOL);
      `CHK("status cleared", 8'h00, rx[7:0])
      `CHK("busy cleared", 1'b0, busy)
    end
    // Flags ignore register writes; writes refused while busy
    pulse(5'h10);
    wr(ADDR_STATUS_TWO_VOL, 8'hff);
    wr(ADDR_CONFIG_ONE_NV, 8'hff);
    host.xfer(24, {40'h0, OPC_WRITE_REGISTERS, 16'h00ff}, rx);
    rd(ADDR_STATUS_TWO_VOL);
    `CHK("status after write", 8'h40, rx[7:0])
    rd(ADDR_CONFIG_ONE_NV);
    `CHK("cfg while busy", 8'h00, rx[7:0])
    op(OPC_CLEAR_STATUS);
    // Slow host, write-registers with status-one byte first
    host.half = 60;
    op(OPC_WRITE_LATCH_SET);
    `CHK("latch set", 1'b1, latch)
    host.xfer(24, {40'h0, OPC_WRITE_REGISTERS, 8'h00, 8'hff}, rx);
    `CHK("latch cleared", 1'b0, latch)
    host.half = 40;
    wr(ADDR_STATUS_TWO_VOL, 8'hff);
    rd(ADDR_STATUS_TWO_VOL);
    `CHK("status not writable", 8'h00, rx[7:0])
    rd(ADDR_CONFIG_ONE_NV);
    `CHK("cfg 01h", 8'h7e, rx[7:0])
    `CHK("lock copy", 4'hf, lock)
    wr(ADDR_CONFIG_ONE_NV, 8'h00);
    rd(ADDR_CONFIG_ONE_NV);
    `CHK("cfg otp kept", 8'h3c, rx[7:0])
    wr(ADDR_CONFIG_ONE_NV, 8'h42);
    rst();
    `CHK("copies", 3'h6, {cmp, four, frz})
    `CHK("halt copy", 1'b0, halt)
    rd(ADDR_CONFIG_ONE_NV);
    `CHK("cfg kept", 8'h7e, rx[7:0])
    rd(24'h000010);
    `CHK("unmapped", 8'h00, rx[7:0])
    host.xfer(16, {48'h0, 8'hc3, 8'h00}, rx);
    `CHK("unknown opcode", 8'hzz, rx[7:0])
    wr(ADDR_CONFIG_ONE_NV, 8'h01);
    rd(ADDR_CONFIG_ONE_NV);
    `CHK("freeze refused", 8'h3c, rx[7:0])
    @(negedge clk);
    sel = REGION_PROTECT_ALL;
    wr(ADDR_CONFIG_ONE_NV, 8'h01);
    rd(ADDR_CONFIG_ONE_NV);
    `CHK("freeze set", 8'h3d, rx[7:0])
    wr(ADDR_CONFIG_ONE_NV, 8'h42);
    rd(ADDR_CONFIG_ONE_NV);
    `CHK("frozen", 8'h3d, rx[7:0])
    rst();
    `CHK("freeze copy", 1'b1, frz)
    summarize();
  end
endmodule : tb_top
